// File: rtl/irq_ctrl_pkg.sv
// Shared constants and carrier types for the four-source interrupt controller
package irq_ctrl_pkg;
	// ************************************************************
	// Register indices and byte addresses on the register bus
	// ************************************************************
	localparam logic [9:0]  IDX_INTERRUPT_CONTROL   = 10'h00B;
	localparam logic [9:0]  IDX_PERIPH_FLAGS        = 10'h00C;
	localparam logic [9:0]  IDX_PERIPH_ENABLES      = 10'h08C;
	localparam logic [9:0]  IDX_EVENT_STATUS        = 10'h010;
	localparam logic [9:0]  IDX_EVENT_CLEAR         = 10'h011;
	localparam logic [9:0]  IDX_EVENT_ENABLE        = 10'h012;
	localparam logic [9:0]  IDX_CORE_STATE          = 10'h013;
	localparam logic [11:0] ADDR_INTERRUPT_CONTROL  = {IDX_INTERRUPT_CONTROL, 2'b00};
	localparam logic [11:0] ADDR_PERIPH_FLAGS       = {IDX_PERIPH_FLAGS, 2'b00};
	localparam logic [11:0] ADDR_PERIPH_ENABLES     = {IDX_PERIPH_ENABLES, 2'b00};
	localparam logic [11:0] ADDR_EVENT_STATUS       = {IDX_EVENT_STATUS, 2'b00};
	localparam logic [11:0] ADDR_EVENT_CLEAR        = {IDX_EVENT_CLEAR, 2'b00};
	localparam logic [11:0] ADDR_EVENT_ENABLE       = {IDX_EVENT_ENABLE, 2'b00};
	localparam logic [11:0] ADDR_CORE_STATE         = {IDX_CORE_STATE, 2'b00};
	// ************************************************************
	// Field positions
	// ************************************************************
	localparam int BIT_GLOBAL_IRQ_ENABLE      = 7;
	localparam int BIT_PERIPHERAL_IRQ_ENABLE  = 6;
	localparam int BIT_TIMER_OVF_IRQ_ENABLE   = 5;
	localparam int BIT_EXT_PIN_IRQ_ENABLE     = 4;
	localparam int BIT_PORT_CHANGE_IRQ_ENABLE = 3;
	localparam int BIT_TIMER_OVF_FLAG         = 2;
	localparam int BIT_EXT_PIN_FLAG           = 1;
	localparam int BIT_PORT_CHANGE_FLAG       = 0;
	localparam int BIT_COMPARATOR_CHANGE      = 6;
	localparam int BIT_EV_VECTOR              = 0;
	localparam int BIT_EV_STACK_WRAP          = 1;
	localparam int BIT_EV_WAKE                = 2;
	// ************************************************************
	// Reset values, vector and stack geometry
	// ************************************************************
	localparam logic [7:0]  RST_INTERRUPT_CONTROL   = 8'h00;
	localparam logic [7:0]  RST_PERIPH              = 8'h00;
	localparam logic [2:0]  RST_EVENTS              = 3'h0;
	localparam int          PC_W                    = 13;
	localparam logic [12:0] IRQ_VECTOR              = 13'h0004;
	localparam int          STACK_DEPTH             = 8;
	localparam logic [3:0]  STACK_FULL_COUNT        = 4'h8;
	// ************************************************************
	// Carrier types
	// ************************************************************
	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} apb_req_t;
	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} apb_rsp_t;
	typedef struct packed {
		logic [12:0] pc;
		logic        call;
		logic        ret;
		logic        return_from_service_instr;
		logic        sleep_cmd;
		logic        wdt_timeout;
		logic        other_reset;
		logic        port_access;
		logic        cmp_read;
	} core_req_t;
	typedef struct packed {
		logic        vector_take;
		logic [12:0] vector_addr;
		logic [12:0] pop_pc;
		logic        force_nop;
		logic        sleeping;
	} core_rsp_t;
endpackage

// File: rtl/irq_ctrl.sv
// Four-source interrupt controller with return-address stack and register slave
// Behaviour
// - Exactly four sources: edge pin, timer overflow, port change, comparator change.
// - Global enable bit 7 set lets unmasked requests in; clear blocks all.
// - Each source has its own enable; a clear enable blocks that source.
// - Every reset clears the global enable.
// - Return-from-service pops the stack and sets the global enable.
// - Entry clears global enable, pushes return address, vectors to 0004h.
// - Pin, port change and timer flags and enables live in control register.
// - Comparator flag and enable are bit 6 of two peripheral registers.
// - Flags set on their event regardless of any enable.
// - Pin or port event reaches the vector in three or four cycles.
// - After a global-enable clear, next cycle is a no-operation; requests stay pending.
// - Power-on zeroes control register; other resets keep the port change flag.
// - Entry saves only the return program counter.
// - Pending enabled request, external reset or watchdog time-out ends sleep.
// - Port change flag is OR of input-pin mismatches against last-read values.
// - Eight-entry circular stack, ninth push overwrites first and sets the stack wrap event.
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module irq_ctrl (
	input  wire logic                    I_CLK,
	input  wire logic                    I_RESET_N,
	input  wire irq_ctrl_pkg::apb_req_t  I_APB,
	output var  irq_ctrl_pkg::apb_rsp_t  O_APB,
	input  wire irq_ctrl_pkg::core_req_t I_CORE,
	output var  irq_ctrl_pkg::core_rsp_t O_CORE,
	input  wire logic                    I_EXT_IRQ_PIN,
	input  wire logic                    I_TIMER_OVF,
	input  wire logic [3:0]              I_CHANGE_DETECT_PINS,
	input  wire logic [3:0]              I_PORT_DIR_IN,
	input  wire logic [1:0]              I_CMP_OUT,
	output logic                         O_IRQ
);
	import irq_ctrl_pkg::*;

	// ************************************************************
	// Declarations
	// ************************************************************
	logic [7:0]      interrupt_control;
	logic            comparator_change_flag;
	logic            comparator_change_enable;
	logic [2:0]      ev_status;
	logic [2:0]      ev_enable;
	logic [6:0]      pin_meta;
	logic [6:0]      pin_sync;
	logic            ext_prev;
	logic [3:0]      port_latch;
	logic [1:0]      cmp_latch;
	logic [PC_W-1:0] stack_mem [STACK_DEPTH];
	logic [2:0]      stack_ptr;
	logic [3:0]      stack_count;
	logic            apb_wr;
	logic            apb_setup;
	logic            ext_rise;
	logic            port_mismatch;
	logic            cmp_mismatch;
	logic            irq_request;
	logic            take;
	logic            push;
	logic            pop;
	logic            gie_clear_write;
	logic            wake;
	logic [2:0]      ev_set;
	logic [31:0]     next_rdata;
	logic            next_slverr;

	// Write strobe that hits one register address
	function automatic logic wr_hit(input logic wr, input logic [11:0] addr, input logic [11:0] target);
		wr_hit = wr && (addr == target);
	endfunction

	// ************************************************************
	// Pin synchronisers and event detection
	// ************************************************************
	// Two flops on every pin before any logic looks at it
	always_ff @(posedge I_CLK) begin
		if (!I_RESET_N) begin
			pin_meta <= 7'h00;
			pin_sync <= 7'h00;
			ext_prev <= 1'b0;
		end else begin
			pin_meta <= {I_CMP_OUT, I_CHANGE_DETECT_PINS, I_EXT_IRQ_PIN};
			pin_sync <= pin_meta;
			ext_prev <= pin_sync[0];
		end
	end

	// Values last seen by the core on port and comparator reads
	always_ff @(posedge I_CLK) begin
		if (!I_RESET_N) begin
			port_latch <= 4'h0;
			cmp_latch  <= 2'h0;
		end else begin
			if (I_CORE.port_access) begin
				port_latch <= pin_sync[4:1];
			end
			if (I_CORE.cmp_read) begin
				cmp_latch <= pin_sync[6:5];
			end
		end
	end

	// Source events for pin, port change and comparator; the timer input is used directly
	assign ext_rise      = pin_sync[0] && !ext_prev;
	assign port_mismatch = |((pin_sync[4:1] ^ port_latch) & I_PORT_DIR_IN);
	assign cmp_mismatch  = |(pin_sync[6:5] ^ cmp_latch);

	// ************************************************************
	// Request qualification and vectoring
	// ************************************************************
	// Each flag gated by its enable, comparator also by peripheral enable
	assign irq_request =
		(interrupt_control[BIT_TIMER_OVF_FLAG] && interrupt_control[BIT_TIMER_OVF_IRQ_ENABLE]) ||
		(interrupt_control[BIT_EXT_PIN_FLAG] && interrupt_control[BIT_EXT_PIN_IRQ_ENABLE]) ||
		(interrupt_control[BIT_PORT_CHANGE_FLAG] && interrupt_control[BIT_PORT_CHANGE_IRQ_ENABLE]) ||
		(comparator_change_flag && comparator_change_enable &&
		 interrupt_control[BIT_PERIPHERAL_IRQ_ENABLE]);
	assign take = interrupt_control[BIT_GLOBAL_IRQ_ENABLE] && irq_request;
	assign push = take || I_CORE.call;
	assign pop  = !push && (I_CORE.ret || I_CORE.return_from_service_instr);
	assign wake = O_CORE.sleeping && (irq_request || I_CORE.wdt_timeout || I_CORE.other_reset);

	// Vector pulse, entry address and forced no-operation
	always_ff @(posedge I_CLK) begin
		if (!I_RESET_N) begin
			O_CORE.vector_take <= 1'b0;
			O_CORE.vector_addr <= 13'h0000;
			O_CORE.force_nop   <= 1'b0;
		end else begin
			O_CORE.vector_take <= take && !I_CORE.other_reset;
			O_CORE.vector_addr <= IRQ_VECTOR;
			O_CORE.force_nop   <= gie_clear_write;
		end
	end

	// Sleep state, ended by any wake source
	always_ff @(posedge I_CLK) begin
		if (!I_RESET_N) begin
			O_CORE.sleeping <= 1'b0;
		end else if (wake) begin
			O_CORE.sleeping <= 1'b0;
		end else if (I_CORE.sleep_cmd) begin
			O_CORE.sleeping <= 1'b1;
		end
	end

	// ************************************************************
	// Return-address stack
	// ************************************************************
	// Circular eight-entry store, only the program counter is kept
	always_ff @(posedge I_CLK) begin
		if (push) begin
			stack_mem[stack_ptr] <= I_CORE.pc;
		end
	end

	// Pointer wraps silently; count only feeds the wrap event
	always_ff @(posedge I_CLK) begin
		if (!I_RESET_N) begin
			stack_ptr     <= 3'h0;
			stack_count   <= 4'h0;
			O_CORE.pop_pc <= 13'h0000;
		end else if (push) begin
			stack_ptr   <= stack_ptr + 3'h1;
			stack_count <= (stack_count == STACK_FULL_COUNT) ? stack_count : stack_count + 4'h1;
		end else if (pop) begin
			stack_ptr     <= stack_ptr - 3'h1;
			stack_count   <= (stack_count == 4'h0) ? 4'h0 : stack_count - 4'h1;
			O_CORE.pop_pc <= stack_mem[stack_ptr - 3'h1];
		end
	end

	// ************************************************************
	// Register bus slave
	// ************************************************************
	assign apb_setup       = I_APB.psel && !I_APB.penable;
	assign apb_wr          = I_APB.psel && I_APB.penable && I_APB.pwrite;
	assign gie_clear_write = wr_hit(apb_wr, I_APB.paddr, ADDR_INTERRUPT_CONTROL) &&
	                         interrupt_control[BIT_GLOBAL_IRQ_ENABLE] && !I_APB.pwdata[BIT_GLOBAL_IRQ_ENABLE];

	// Control register: flags set by events win over software writes
	always_ff @(posedge I_CLK) begin
		if (!I_RESET_N) begin
			interrupt_control <= RST_INTERRUPT_CONTROL;
		end else if (I_CORE.other_reset) begin
			interrupt_control <= {7'h00, interrupt_control[BIT_PORT_CHANGE_FLAG]};
		end else begin
			if (wr_hit(apb_wr, I_APB.paddr, ADDR_INTERRUPT_CONTROL)) begin
				interrupt_control <= I_APB.pwdata[7:0];
			end
			if (take) begin
				interrupt_control[BIT_GLOBAL_IRQ_ENABLE] <= 1'b0;
			end else if (I_CORE.return_from_service_instr) begin
				interrupt_control[BIT_GLOBAL_IRQ_ENABLE] <= 1'b1;
			end
			if (I_TIMER_OVF) begin
				interrupt_control[BIT_TIMER_OVF_FLAG] <= 1'b1;
			end
			if (ext_rise) begin
				interrupt_control[BIT_EXT_PIN_FLAG] <= 1'b1;
			end
			if (port_mismatch) begin
				interrupt_control[BIT_PORT_CHANGE_FLAG] <= 1'b1;
			end
		end
	end

	// Peripheral flag and enable, bit 6 only
	always_ff @(posedge I_CLK) begin
		if (!I_RESET_N || I_CORE.other_reset) begin
			comparator_change_flag   <= RST_PERIPH[BIT_COMPARATOR_CHANGE];
			comparator_change_enable <= RST_PERIPH[BIT_COMPARATOR_CHANGE];
		end else begin
			if (cmp_mismatch) begin
				comparator_change_flag <= 1'b1;
			end else if (wr_hit(apb_wr, I_APB.paddr, ADDR_PERIPH_FLAGS)) begin
				comparator_change_flag <= I_APB.pwdata[BIT_COMPARATOR_CHANGE];
			end
			if (wr_hit(apb_wr, I_APB.paddr, ADDR_PERIPH_ENABLES)) begin
				comparator_change_enable <= I_APB.pwdata[BIT_COMPARATOR_CHANGE];
			end
		end
	end

	// Sticky block events, write-one-to-clear, set wins
	assign ev_set = {wake, push && (stack_count == STACK_FULL_COUNT), take && !I_CORE.other_reset};
	always_ff @(posedge I_CLK) begin
		if (!I_RESET_N) begin
			ev_status <= RST_EVENTS;
			ev_enable <= RST_EVENTS;
		end else begin
			if (wr_hit(apb_wr, I_APB.paddr, ADDR_EVENT_CLEAR)) begin
				ev_status <= (ev_status & ~I_APB.pwdata[2:0]) | ev_set;
			end else begin
				ev_status <= ev_status | ev_set;
			end
			if (wr_hit(apb_wr, I_APB.paddr, ADDR_EVENT_ENABLE)) begin
				ev_enable <= I_APB.pwdata[2:0];
			end
		end
	end

	// Interrupt line, one cycle behind the status it reflects
	always_ff @(posedge I_CLK) begin
		if (!I_RESET_N) begin
			O_IRQ <= 1'b0;
		end else begin
			O_IRQ <= |(ev_status & ev_enable);
		end
	end

	// Read mux; unmapped addresses answer with an error
	always_comb begin
		next_rdata  = 32'h0000_0000;
		next_slverr = 1'b0;
		case (I_APB.paddr)
			ADDR_INTERRUPT_CONTROL: next_rdata[7:0] = interrupt_control;
			ADDR_PERIPH_FLAGS:      next_rdata[BIT_COMPARATOR_CHANGE] = comparator_change_flag;
			ADDR_PERIPH_ENABLES:    next_rdata[BIT_COMPARATOR_CHANGE] = comparator_change_enable;
			ADDR_EVENT_STATUS:      next_rdata[2:0] = ev_status;
			ADDR_EVENT_CLEAR:       next_rdata = 32'h0000_0000;
			ADDR_EVENT_ENABLE:      next_rdata[2:0] = ev_enable;
			ADDR_CORE_STATE:        next_rdata[7:0] = {1'b0, stack_ptr, 2'b00, irq_request, O_CORE.sleeping};
			default:                next_slverr = 1'b1;
		endcase
	end

	// Answer captured in setup, shown through the zero-wait access phase
	always_ff @(posedge I_CLK) begin
		if (!I_RESET_N) begin
			O_APB.prdata  <= 32'h0000_0000;
			O_APB.pslverr <= 1'b0;
			O_APB.pready  <= 1'b0;
		end else begin
			O_APB.pready <= 1'b1;
			if (apb_setup) begin
				O_APB.prdata  <= I_APB.pwrite ? 32'h0000_0000 : next_rdata;
				O_APB.pslverr <= next_slverr;
			end
		end
	end

	// ************************************************************
	// Assertions
	// ************************************************************
	AST_ENTRY_CLEARS_ENABLE: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
		O_CORE.vector_take |-> !interrupt_control[BIT_GLOBAL_IRQ_ENABLE] && O_CORE.vector_addr == IRQ_VECTOR)
		else $error("vector taken with enable set or wrong address");
	AST_NO_ENTRY_WHEN_MASKED: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
		!interrupt_control[BIT_GLOBAL_IRQ_ENABLE] |=> !O_CORE.vector_take)
		else $error("vector taken while global enable clear");
	AST_RETURN_SETS_ENABLE: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
		I_CORE.return_from_service_instr && !take && !I_CORE.other_reset |=> interrupt_control[BIT_GLOBAL_IRQ_ENABLE])
		else $error("return did not set global enable");
	AST_TIMER_FLAG_ALWAYS: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
		I_TIMER_OVF && !I_CORE.other_reset |=> interrupt_control[BIT_TIMER_OVF_FLAG])
		else $error("timer flag not set");
	AST_EXT_LATENCY: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
		ext_rise && interrupt_control[BIT_EXT_PIN_IRQ_ENABLE] && interrupt_control[BIT_GLOBAL_IRQ_ENABLE] &&
		!I_CORE.other_reset && !gie_clear_write && !take |=> ##1 O_CORE.vector_take || $past(take))
		else $error("pin event did not vector in time");
	AST_NOP_AFTER_CLEAR: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
		gie_clear_write && !I_CORE.return_from_service_instr |=> O_CORE.force_nop ##1 !O_CORE.vector_take)
		else $error("no-operation missing after enable clear");
	AST_STACK_WRAPS: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
		push && stack_ptr == 3'h7 |=> stack_ptr == 3'h0)
		else $error("stack pointer did not wrap");
	AST_PERIPH_GATE: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
		!interrupt_control[BIT_PERIPHERAL_IRQ_ENABLE] && !(|(interrupt_control[5:3] & interrupt_control[2:0]))
		|=> !O_CORE.vector_take)
		else $error("comparator interrupt without peripheral enable");
	AST_WAKE_ON_TIMEOUT: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
		O_CORE.sleeping && I_CORE.wdt_timeout |=> !O_CORE.sleeping)
		else $error("sleep not ended by time-out");
	AST_PORT_CHANGE_SETS: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
		port_mismatch && !I_CORE.other_reset |=> interrupt_control[BIT_PORT_CHANGE_FLAG])
		else $error("port change flag not set");
	AST_OTHER_RESET_KEEPS: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
		I_CORE.other_reset |=> interrupt_control[7:1] == 7'h00 &&
		interrupt_control[BIT_PORT_CHANGE_FLAG] == $past(interrupt_control[BIT_PORT_CHANGE_FLAG]))
		else $error("other reset value wrong");
	// Source flags latch on their event whatever the enables say
	AST_EXT_FLAG_SETS: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
		ext_rise && !I_CORE.other_reset |=> interrupt_control[BIT_EXT_PIN_FLAG])
		else $error("pin flag not set");
	AST_CMP_FLAG_SETS: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
		cmp_mismatch && !I_CORE.other_reset |=> comparator_change_flag)
		else $error("comparator flag not set");
	// Clear-type reset leaves the global enable off
	AST_RESET_CLEARS_GIE: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
		I_CORE.other_reset |=> !interrupt_control[BIT_GLOBAL_IRQ_ENABLE])
		else $error("global enable survived reset");
	// Pending enabled request ends sleep
	AST_WAKE_ON_REQUEST: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
		O_CORE.sleeping && irq_request |=> !O_CORE.sleeping)
		else $error("sleep not ended by request");
	// Entry pulse lasts one cycle only
	AST_VECTOR_PULSE: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
		O_CORE.vector_take |=> !O_CORE.vector_take)
		else $error("vector pulse longer than one cycle");
	AST_PUSH_POP_PC: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
		push && !I_CORE.other_reset ##1 pop |=> O_CORE.pop_pc == $past(I_CORE.pc, 2))
		else $error("popped address differs from pushed");
endmodule
`default_nettype wire

// File: dv/core_model.sv
// Core sequencer and event source model facing the interrupt controller
`timescale 1ns/100ps
`default_nettype none
module core_model (
	input  wire logic                    I_CLK,
	input  wire irq_ctrl_pkg::core_rsp_t I_CORE_RSP,
	output var  irq_ctrl_pkg::core_req_t O_CORE_REQ,
	output var  logic                    O_TIMER_OVF
);
	import irq_ctrl_pkg::*;
	// Idle at time zero
	initial begin
		O_CORE_REQ  = '0;
		O_TIMER_OVF = 1'b0;
	end
	// Core jumps to the vector when entry is signalled
	always @(posedge I_CLK) begin
		if (I_CORE_RSP.vector_take === 1'b1) begin
			O_CORE_REQ.pc <= I_CORE_RSP.vector_addr;
		end
	end
	// One-cycle command or timer pulse at a given program counter
	task automatic fire(input logic [8:0] m, input logic [12:0] a);
		@(posedge I_CLK);
		O_CORE_REQ.pc   <= a;
		O_CORE_REQ[7:0] <= m[7:0];
		O_TIMER_OVF     <= m[8];
		@(posedge I_CLK);
		O_CORE_REQ[7:0] <= 8'h00;
		O_TIMER_OVF     <= 1'b0;
	endtask
endmodule
`default_nettype wire

// File: dv/testbench.sv
// Self-checking bench for the four-source interrupt controller
`timescale 1ns/100ps
`default_nettype none
module testbench;
	import irq_ctrl_pkg::*;
	localparam logic [8:0] C_CALL = 9'h080, C_RET = 9'h040, C_RFS = 9'h020, C_SLEEP = 9'h010;
	localparam logic [8:0] C_ORST = 9'h004, C_PORT = 9'h002, C_CMP = 9'h001, C_TMR = 9'h100;
	localparam logic [11:0] CTL = ADDR_INTERRUPT_CONTROL;
	logic		clk, rst_n, ext_pin, irq, timer, serr;
	logic [3:0]	chg, dir;
	logic [1:0]	cmp;
	logic [7:0]	v;
	logic [31:0]	rdat, lfsr;
	apb_req_t	apb_req;
	apb_rsp_t	apb_rsp;
	core_req_t	core_req;
	core_rsp_t	core_rsp;
	int		err_total, compares, n, i;
	irq_ctrl u_irq_ctrl (.I_CLK(clk), .I_RESET_N(rst_n), .I_APB(apb_req), .O_APB(apb_rsp), .I_CORE(core_req),
		.O_CORE(core_rsp), .I_EXT_IRQ_PIN(ext_pin), .I_TIMER_OVF(timer), .I_CHANGE_DETECT_PINS(chg),
		.I_PORT_DIR_IN(dir), .I_CMP_OUT(cmp), .O_IRQ(irq));
	core_model u_core_model (.I_CLK(clk), .I_CORE_RSP(core_rsp), .O_CORE_REQ(core_req), .O_TIMER_OVF(timer));
	// 40 MHz clock
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// ****************************************
	// Tasks and expectation functions
	// ****************************************
	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [31:0] ctl_after_reset(input logic [7:0] c);
		return {31'h0, c[BIT_PORT_CHANGE_FLAG]};
	endfunction
	task automatic test_done();
		$display("Comparisons %0d, mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// One bus transfer, held until pready is seen
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int k;
		@(posedge clk);
		apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
		@(posedge clk);
		apb_req.penable <= 1'b1;
		for (k = 0; k < 16; k++) begin
			@(posedge clk);
			if (apb_rsp.pready === 1'b1) begin
				break;
			end
		end
		rdat = apb_rsp.prdata;
		serr = apb_rsp.pslverr;
		apb_req.psel <= 1'b0;
		apb_req.penable <= 1'b0;
		if (k == 16) begin
			err_total++;
			test_done();
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		apb(1'b1, a, {24'h0, d});
	endtask
	task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rdat, exp);
	endtask
	// Count edges until vector entry; a required one that never comes ends the run
	task automatic wait_vec(input int lim, input logic must);
		n = 0;
		for (int k = 1; k <= lim && n == 0; k++) begin
			@(posedge clk);
			#1;
			if (core_rsp.vector_take === 1'b1) begin
				n = k;
			end
		end
		if (must && n == 0) begin
			err_total++;
			test_done();
		end
	endtask
	// Hang guard
	initial begin
		#500000;
		err_total++;
		test_done();
	end
	// ****************************************
	// Scenarios
	// ****************************************
	initial begin
		rst_n = 1'b0;
		apb_req = '0;
		ext_pin = 1'b0;
		chg = 4'h0;
		dir = 4'hF;
		cmp = 2'h0;
		err_total = 0;
		compares = 0;
		lfsr = 32'h3B28;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		rd_chk(CTL, {24'h0, RST_INTERRUPT_CONTROL});
		rd_chk(ADDR_PERIPH_ENABLES, 32'h0);
		apb(1'b0, 12'h100, 32'h0);
		chk({31'h0, serr}, 32'h1);
		// Timer entry, return and forced no-operation
		wr(ADDR_EVENT_ENABLE, 8'h01);
		wr(CTL, 8'hA0);
		u_core_model.fire(C_TMR, 13'h0123);
		wait_vec(4, 1'b1);
		chk(n, 1);
		chk({19'h0, core_rsp.vector_addr}, {19'h0, IRQ_VECTOR});
		rd_chk(CTL, 32'h24);
		wr(CTL, 8'h20);
		u_core_model.fire(C_RFS, IRQ_VECTOR);
		#1;
		chk({19'h0, core_rsp.pop_pc}, 32'h123);
		rd_chk(CTL, 32'hA0);
		wr(CTL, 8'h00);
		#1;
		chk({31'h0, core_rsp.force_nop}, 32'h1);
		// Interrupt line masked, unmasked and cleared
		chk({31'h0, irq}, 32'h1);
		for (i = 0; i < 3; i++) begin
			wr((i == 2) ? ADDR_EVENT_CLEAR : ADDR_EVENT_ENABLE, (i == 0) ? 8'h00 : 8'h01);
			@(posedge clk);
			#1;
			chk({31'h0, irq}, {31'h0, i == 1});
		end
		rd_chk(ADDR_EVENT_STATUS, 32'h0);
		// Pin edge and port change latency
		u_core_model.fire(C_PORT, 13'h0200);
		for (i = 0; i < 2; i++) begin
			wr(CTL, (i == 1) ? 8'h88 : 8'h90);
			@(posedge clk);
			if (i == 1) begin
				chg <= 4'h4;
			end else begin
				ext_pin <= 1'b1;
			end
			wait_vec(6, 1'b1);
			chk({31'h0, n == 3 || n == 4}, 32'h1);
			u_core_model.fire(C_PORT, IRQ_VECTOR);
			wr(CTL, 8'h00);
		end
		// Output-configured pins never raise the port change flag
		@(posedge clk);
		dir <= 4'h0;
		chg <= 4'h8;
		repeat (4) @(posedge clk);
		rd_chk(CTL, 32'h0);
		chg <= 4'h4;
		repeat (3) @(posedge clk);
		dir <= 4'hF;
		// Comparator held off until the peripheral enable
		wr(ADDR_PERIPH_ENABLES, 8'h40);
		u_core_model.fire(C_CMP, 13'h0300);
		wr(CTL, 8'h80);
		@(posedge clk);
		cmp <= 2'b01;
		wait_vec(6, 1'b0);
		chk(n, 0);
		rd_chk(ADDR_PERIPH_FLAGS, 32'h40);
		wr(CTL, 8'hC0);
		wait_vec(4, 1'b1);
		u_core_model.fire(C_CMP, IRQ_VECTOR);
		wr(ADDR_PERIPH_FLAGS, 8'h00);
		// Random control values, then a clear reset
		for (i = 0; i < 6; i++) begin
			lfsr = lfsr_next(lfsr);
			v = lfsr[7:0] & 8'h7F;
			wr(CTL, v);
			rd_chk(CTL, {24'h0, v});
		end
		wr(ADDR_PERIPH_ENABLES, 8'h40);
		wr(CTL, 8'h81);
		u_core_model.fire(C_ORST, 13'h0000);
		rd_chk(CTL, ctl_after_reset(8'h81));
		rd_chk(ADDR_PERIPH_ENABLES, 32'h0);
		// Sleep ended by an enabled request
		wr(CTL, 8'h20);
		u_core_model.fire(C_SLEEP, 13'h0000);
		#1;
		chk({31'h0, core_rsp.sleeping}, 32'h1);
		u_core_model.fire(C_TMR, 13'h0000);
		for (i = 0; i < 4 && core_rsp.sleeping === 1'b1; i++) begin
			@(posedge clk);
			#1;
		end
		chk({31'h0, core_rsp.sleeping}, 32'h0);
		wr(CTL, 8'h00);
		// Watchdog time-out ends sleep as well
		u_core_model.fire(C_SLEEP, 13'h0000);
		u_core_model.fire(9'h008, 13'h0000);
		#1;
		chk({31'h0, core_rsp.sleeping}, 32'h0);
		// Stack wraps after eight entries
		for (i = 1; i <= 9; i++) begin
			u_core_model.fire(C_CALL, i[12:0]);
		end
		for (i = 0; i < 8; i++) begin
			u_core_model.fire(C_RET, 13'h0000);
			#1;
			chk({19'h0, core_rsp.pop_pc}, 32'(9 - i));
		end
		apb(1'b0, ADDR_EVENT_STATUS, 32'h0);
		chk(rdat & 32'h2, 32'h2);
		test_done();
	end
endmodule
`default_nettype wire
